// [net_cfg_pkg.sv]
// constants, field layouts and carriers of the network configuration
// and first setup registers; assumes a 50 MHz controller clock
package net_cfg_pkg;

  // ==========================================================
  // host register map
  localparam logic [2:0] CFG_ADDR    = 3'h6;
  localparam logic [2:0] SUBREG_ADDR = 3'h7;
  localparam int         CFG_RST_BIT  = 7;
  localparam int         CFG_TRANSMIT_ENABLE_BIT_BIT = 5;
  localparam logic [7:0] CFG_RST_VAL  = 8'h00;
  localparam logic [7:0] SETUP_RST_VAL = 8'h00;
  localparam logic [7:0] SETUP_WMASK  = 8'hdf;

  typedef enum logic [2:0] {
    SEL_TENT_ID  = 3'h0,
    SEL_NODE_ID  = 3'h1,
    SEL_SETUP1   = 3'h2,
    SEL_NEXT_ID  = 3'h3,
    SEL_SETUP2   = 3'h4,
    SEL_BUS_CTRL = 3'h5,
    SEL_DMA_CNT  = 3'h6,
    SEL_RSVD     = 3'h7
  } reg_target_e;

  // ==========================================================
  // timeout selection
  localparam logic [1:0] ET_LONGEST  = 2'h0;
  localparam logic [1:0] ET_LONG     = 2'h1;
  localparam logic [1:0] ET_SHORT    = 2'h2;
  localparam logic [1:0] ET_SHORTEST = 2'h3;
  localparam int  TO_W          = 32;
  localparam real CLK_MHZ       = 50.0;
  localparam real US_PER_MS     = 1000.0;
  localparam real RESP0_US      = 298.4;
  localparam real RESP1_US      = 149.2;
  localparam real RESP2_US      = 74.7;
  localparam real RESP3_US      = 18.7;
  localparam real IDLE0_US      = 328.0;
  localparam real IDLE1_US      = 164.0;
  localparam real IDLE2_US      = 82.0;
  localparam real IDLE3_US      = 20.5;
  localparam real RCFG_LONG_MS  = 420.0;
  localparam real RCFG_SHORT_MS = 210.0;
  localparam int unsigned RESP0_CYC = int'(RESP0_US * CLK_MHZ);
  localparam int unsigned RESP1_CYC = int'(RESP1_US * CLK_MHZ);
  localparam int unsigned RESP2_CYC = int'(RESP2_US * CLK_MHZ);
  localparam int unsigned RESP3_CYC = int'(RESP3_US * CLK_MHZ);
  localparam int unsigned IDLE0_CYC = int'(IDLE0_US * CLK_MHZ);
  localparam int unsigned IDLE1_CYC = int'(IDLE1_US * CLK_MHZ);
  localparam int unsigned IDLE2_CYC = int'(IDLE2_US * CLK_MHZ);
  localparam int unsigned IDLE3_CYC = int'(IDLE3_US * CLK_MHZ);
  localparam int unsigned RCFG_LONG_CYC  = int'(RCFG_LONG_MS * US_PER_MS * CLK_MHZ);
  localparam int unsigned RCFG_SHORT_CYC = int'(RCFG_SHORT_MS * US_PER_MS * CLK_MHZ);

  // ==========================================================
  // nack threshold and rate prescaler
  localparam int NACK_W    = 8;
  localparam logic [7:0] NACK_FEW  = 8'h04;
  localparam logic [7:0] NACK_MANY = 8'h80;
  localparam int PRESC_BASE_SHIFT = 3;
  localparam logic [2:0] PRESC_MAX_CODE = 3'h4;
  localparam int PRESC_W = 7;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       sw_reset;
    logic       command_chain_enable;
    logic       transmit_enable_bit;
    logic [1:0] extended_timeout_select;
    logic       backplane;
    logic [1:0] register_select_low;
  } net_cfg_s;

  typedef struct packed {
    logic       pulse_driver_type;
    logic       nack_threshold_select;
    logic       rsvd;
    logic       receive_everything;
    logic [2:0] rate_prescaler;
    logic       halved_arbitration;
  } setup_first_s;

  typedef struct packed {
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] dest;
  } pkt_s;

  typedef struct packed {
    logic tx_active;
    logic p1;
    logic p2;
  } pulse_req_s;

  typedef struct packed {
    logic [TO_W-1:0] resp;
    logic [TO_W-1:0] idle;
    logic [TO_W-1:0] rcfg;
  } timeouts_s;

endpackage : net_cfg_pkg

// [nack_threshold_counter.sv]
// counts nack replies to free buffer enquiries and raises a sticky flag
// assumes events and clear come from logic on the same clock
`timescale 1ns/1ps
module nack_threshold_counter #(
  parameter int W = net_cfg_pkg::NACK_W
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  input  wire logic clr,
  input  wire logic few,
  input  wire logic nack_seen,
  output logic      flag
);
  import net_cfg_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         flag;
  } cnt_st_s;

  cnt_st_s      st_ff;
  cnt_st_s      nxt_st;
  logic [W-1:0] thr;

  if (W < NACK_W) begin : g_bad_w
    $error("counter too narrow for the threshold");
  end

  // ==========================================================
  // counting
  always_comb
  begin
    nxt_st = st_ff;
    thr    = W'(few ? NACK_FEW : NACK_MANY);
    if (clr)
    begin
      nxt_st = '0;
    end
    if (nack_seen && (nxt_st.cnt < thr))
    begin
      nxt_st.cnt = nxt_st.cnt + W'(1);
    end
    if (nack_seen && (nxt_st.cnt >= thr))
    begin
      nxt_st.flag = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign flag = st_ff.flag;

  property p_flag_needs_count;
    @(posedge clk) disable iff (sys_rst)
      (ce && !clr && $rose(st_ff.flag)) |-> (st_ff.cnt >= (few ? NACK_FEW : NACK_MANY));
  endproperty
  a_flag_needs_count: assert property (p_flag_needs_count)
    else $error("nack flag set below threshold");

endmodule : nack_threshold_counter

// [rate_prescaler_divider.sv]
// divides the controller clock into a data rate tick by 8 to 128
// assumes the clock is the 50 MHz controller clock, multiplier bypassed
`timescale 1ns/1ps
module rate_prescaler_divider #(
  parameter int CW = net_cfg_pkg::PRESC_W
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  input  wire logic [2:0] code,
  output logic            tick
);
  import net_cfg_pkg::*;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } div_st_s;

  div_st_s       st_ff;
  div_st_s       nxt_st;
  logic [2:0]    eff;
  logic [CW-1:0] last;

  if (CW < PRESC_BASE_SHIFT + int'(PRESC_MAX_CODE)) begin : g_bad_cw
    $error("divider counter too narrow");
  end

  // ==========================================================
  // divide by 8 shifted left by the code, codes above 100 act as 100
  always_comb
  begin
    nxt_st = st_ff;
    eff    = (code > PRESC_MAX_CODE) ? PRESC_MAX_CODE : code;
    last   = CW'((1 << (PRESC_BASE_SHIFT + int'(eff))) - 1);
    nxt_st.tick = 1'b0;
    if (st_ff.cnt >= last)
    begin
      nxt_st.cnt  = '0;
      nxt_st.tick = 1'b1;
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

  property p_tick_spacing;
    @(posedge clk) disable iff (sys_rst)
      (ce && st_ff.tick) |=> !st_ff.tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("rate tick closer than divide by eight");

endmodule : rate_prescaler_divider

// [token_net_config_setup_regs.sv]
// configuration register and first setup register of the token network
// controller; assumes host strobes and engine events share clk
`timescale 1ns/1ps
module token_net_config_setup_regs
  import net_cfg_pkg::*;
#(
  parameter int unsigned RESP_LONGEST_CYC = net_cfg_pkg::RESP0_CYC,
  parameter int unsigned RESP_LONG_CYC    = net_cfg_pkg::RESP1_CYC,
  parameter int unsigned IDLE_LONGEST_CYC = net_cfg_pkg::IDLE0_CYC,
  parameter int unsigned IDLE_LONG_CYC    = net_cfg_pkg::IDLE1_CYC,
  parameter int unsigned IDLE_SHORT_CYC   = net_cfg_pkg::IDLE2_CYC,
  parameter int unsigned RCFG_LONG_P_CYC  = net_cfg_pkg::RCFG_LONG_CYC,
  parameter int unsigned RCFG_SHORT_P_CYC = net_cfg_pkg::RCFG_SHORT_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     ce,
  input  wire net_cfg_pkg::host_req_s   host_req,
  input  wire logic [7:0]               ext_rdata,
  input  wire logic                     register_select_high,
  input  wire logic [1:0]               reconfig_time_multiplier,
  input  wire logic                     nack_seen,
  input  wire net_cfg_pkg::pkt_s        pkt,
  input  wire logic [7:0]               node_id,
  input  wire net_cfg_pkg::pulse_req_s  pulse_req,
  output logic [7:0]                    host_rdata,
  output logic                          software_reset,
  output logic                          command_chain_enable,
  output logic                          backplane_mode,
  output net_cfg_pkg::reg_target_e      register_target,
  output net_cfg_pkg::timeouts_s        timeouts,
  output logic                          first_pulse_output_n,
  output logic                          first_pulse_oe,
  output logic                          second_pulse_output_n,
  output logic                          tx_enable_pin,
  output logic                          packet_accept,
  output logic                          packet_ack,
  output logic                          excessive_nack_flag,
  output logic                          rate_tick,
  output logic                          arb_tick
);
  import net_cfg_pkg::*;

  typedef struct packed {
    net_cfg_s     cfg;
    setup_first_s su;
    logic [7:0]   rdata;
    reg_target_e  target;
    timeouts_s    to;
    logic         p1_n;
    logic         p1_oe;
    logic         p2_n;
    logic         txpin;
    logic         accept;
    logic         ack;
    logic         arb;
  } regs_st_s;

  regs_st_s        st_ff;
  regs_st_s        nxt_st;
  reg_target_e     sel;
  logic            cfg_wr;
  logic            su_wr;
  logic            gate;
  logic            dest_hit;
  logic [TO_W-1:0] rcfg_base;

  // ==========================================================
  // parameter checks
  if ((RESP_LONGEST_CYC == 0) || (RESP_LONG_CYC == 0) || (IDLE_LONGEST_CYC == 0) ||
      (IDLE_LONG_CYC == 0) || (IDLE_SHORT_CYC == 0) || (RCFG_LONG_P_CYC == 0) ||
      (RCFG_SHORT_P_CYC == 0)) begin : g_bad_zero
    $error("timeout counts must be at least one cycle");
  end
  if (RCFG_LONG_P_CYC >= (1 << (TO_W - 4))) begin : g_bad_rcfg
    $error("reconfiguration count overflows when multiplied");
  end

  // ==========================================================
  // register access and derived controls
  always_comb
  begin
    nxt_st    = st_ff;
    sel       = reg_target_e'({register_select_high, st_ff.cfg.register_select_low});
    cfg_wr    = host_req.wr && (host_req.addr == CFG_ADDR);
    su_wr     = host_req.wr && (host_req.addr == SUBREG_ADDR) && (sel == SEL_SETUP1);
    gate      = st_ff.cfg.transmit_enable_bit && !st_ff.cfg.sw_reset;
    dest_hit  = (pkt.dest == node_id);
    rcfg_base = TO_W'(RCFG_LONG_P_CYC);

    // configuration write, including set and release of software reset
    if (cfg_wr)
    begin
      nxt_st.cfg = net_cfg_s'(host_req.wdata);
    end
    // setup write through address 07; software reset does not touch it
    if (su_wr)
    begin
      nxt_st.su = setup_first_s'(host_req.wdata & SETUP_WMASK);
    end
    nxt_st.target = sel;

    // read mux, registered
    if (host_req.rd)
    begin
      if (host_req.addr == CFG_ADDR)
      begin
        nxt_st.rdata = st_ff.cfg;
      end
      else if ((host_req.addr == SUBREG_ADDR) && (sel == SEL_SETUP1))
      begin
        nxt_st.rdata = st_ff.su;
      end
      else
      begin
        nxt_st.rdata = ext_rdata;
      end
    end

    // timeout selection
    case (st_ff.cfg.extended_timeout_select)
      ET_LONGEST:
      begin
        nxt_st.to.resp = TO_W'(RESP_LONGEST_CYC);
        nxt_st.to.idle = TO_W'(IDLE_LONGEST_CYC);
        rcfg_base      = TO_W'(RCFG_LONG_P_CYC);
      end
      ET_LONG:
      begin
        nxt_st.to.resp = TO_W'(RESP_LONG_CYC);
        nxt_st.to.idle = TO_W'(IDLE_LONG_CYC);
        rcfg_base      = TO_W'(RCFG_LONG_P_CYC);
      end
      ET_SHORT:
      begin
        nxt_st.to.resp = TO_W'(RESP2_CYC);
        nxt_st.to.idle = TO_W'(IDLE_SHORT_CYC);
        rcfg_base      = TO_W'(RCFG_LONG_P_CYC);
      end
      default:
      begin
        nxt_st.to.resp = TO_W'(RESP3_CYC);
        nxt_st.to.idle = TO_W'(IDLE3_CYC);
        rcfg_base      = TO_W'(RCFG_SHORT_P_CYC);
      end
    endcase
    nxt_st.to.rcfg = rcfg_base << reconfig_time_multiplier;

    // pulse outputs and transmit pin
    nxt_st.txpin = gate && pulse_req.tx_active;
    if (st_ff.cfg.backplane)
    begin
      nxt_st.p2_n = 1'b1;
      nxt_st.p1_n = !(gate && pulse_req.p1);
      if (st_ff.su.pulse_driver_type)
      begin
        nxt_st.p1_oe = 1'b1;
      end
      else
      begin
        nxt_st.p1_oe = gate && pulse_req.p1;
      end
    end
    else
    begin
      nxt_st.p1_oe = 1'b1;
      nxt_st.p1_n  = !(gate && pulse_req.p1);
      nxt_st.p2_n  = !(gate && pulse_req.p2);
    end

    // receive filter and acknowledge
    nxt_st.accept = pkt.valid && !st_ff.cfg.sw_reset &&
                    (st_ff.su.receive_everything || dest_hit);
    nxt_st.ack    = pkt.valid && !st_ff.cfg.sw_reset && dest_hit;

    // arbitration clock enable
    nxt_st.arb = st_ff.su.halved_arbitration ? !st_ff.arb : 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_ff         <= '0;
      st_ff.cfg     <= net_cfg_s'(CFG_RST_VAL);
      st_ff.su      <= setup_first_s'(SETUP_RST_VAL);
      st_ff.to.resp <= TO_W'(RESP_LONGEST_CYC);
      st_ff.to.idle <= TO_W'(IDLE_LONGEST_CYC);
      st_ff.to.rcfg <= TO_W'(RCFG_LONG_P_CYC);
      st_ff.p1_n    <= 1'b1;
      st_ff.p1_oe   <= 1'b1;
      st_ff.p2_n    <= 1'b1;
      st_ff.arb     <= 1'b1;
    end
    else if (ce)
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // diagnostics and rate
  nack_threshold_counter #(
    .W (NACK_W)
  ) u_nack (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .clr       (st_ff.cfg.sw_reset),
    .few       (st_ff.su.nack_threshold_select),
    .nack_seen (nack_seen),
    .flag      (excessive_nack_flag)
  );

  rate_prescaler_divider #(
    .CW (PRESC_W)
  ) u_rate (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .code    (st_ff.su.rate_prescaler),
    .tick    (rate_tick)
  );

  // ==========================================================
  // outputs
  assign host_rdata            = st_ff.rdata;
  assign software_reset        = st_ff.cfg.sw_reset;
  assign command_chain_enable  = st_ff.cfg.command_chain_enable;
  assign backplane_mode        = st_ff.cfg.backplane;
  assign register_target       = st_ff.target;
  assign timeouts              = st_ff.to;
  assign first_pulse_output_n  = st_ff.p1_n;
  assign first_pulse_oe        = st_ff.p1_oe;
  assign second_pulse_output_n = st_ff.p2_n;
  assign tx_enable_pin         = st_ff.txpin;
  assign packet_accept         = st_ff.accept;
  assign packet_ack            = st_ff.ack;
  assign arb_tick              = st_ff.arb;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_rst_written;
    ce && cfg_wr && host_req.wdata[CFG_RST_BIT];
  endsequence
  sequence s_rst_released;
    ce && cfg_wr && !host_req.wdata[CFG_RST_BIT];
  endsequence

  property p_swrst_enter;
    s_rst_written |=> software_reset;
  endproperty
  a_swrst_enter: assert property (p_swrst_enter)
    else $error("software reset not entered");

  property p_swrst_hold;
    (software_reset && !(ce && cfg_wr)) |=> software_reset;
  endproperty
  a_swrst_hold: assert property (p_swrst_hold)
    else $error("software reset released without host write");

  property p_swrst_exit;
    (software_reset and s_rst_released) |=> !software_reset;
  endproperty
  a_swrst_exit: assert property (p_swrst_exit)
    else $error("software reset not released");

  property p_setup_kept;
    (ce && !su_wr) |=> $stable(st_ff.su);
  endproperty
  a_setup_kept: assert property (p_setup_kept)
    else $error("setup changed without a write");

  property p_diag_cleared;
    (ce && software_reset) ##1 (ce && software_reset) |=> !excessive_nack_flag;
  endproperty
  a_diag_cleared: assert property (p_diag_cleared)
    else $error("nack flag survived software reset");

  property p_tx_off;
    (ce && !st_ff.cfg.transmit_enable_bit) |=> (!tx_enable_pin && second_pulse_output_n &&
                                               first_pulse_output_n);
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("pulse or transmit pin active while transmit disabled");

  property p_shortest_times;
    (ce && (st_ff.cfg.extended_timeout_select == ET_SHORTEST)) |=>
      ((timeouts.resp == TO_W'(RESP3_CYC)) && (timeouts.idle == TO_W'(IDLE3_CYC)));
  endproperty
  a_shortest_times: assert property (p_shortest_times)
    else $error("shortest timeout row not applied");

  property p_rcfg_scaled;
    (ce && (st_ff.cfg.extended_timeout_select != ET_SHORTEST)) |=>
      (timeouts.rcfg == (TO_W'(RCFG_LONG_P_CYC) << $past(reconfig_time_multiplier)));
  endproperty
  a_rcfg_scaled: assert property (p_rcfg_scaled)
    else $error("reconfiguration time not scaled");

  property p_open_drain;
    (ce && st_ff.cfg.backplane && !st_ff.su.pulse_driver_type) |=>
      (first_pulse_oe == !first_pulse_output_n);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pulse driven high");

  property p_ack_own;
    packet_ack |-> $past(pkt.dest == node_id);
  endproperty
  a_ack_own: assert property (p_ack_own)
    else $error("acknowledge for foreign destination");

  property p_receive_all;
    (ce && pkt.valid && st_ff.su.receive_everything && !software_reset) |=> packet_accept;
  endproperty
  a_receive_all: assert property (p_receive_all)
    else $error("packet dropped in receive everything mode");

  property p_arb_halved;
    (ce && st_ff.su.halved_arbitration && arb_tick) |=> !arb_tick;
  endproperty
  a_arb_halved: assert property (p_arb_halved)
    else $error("arbitration clock not halved");

  property p_target;
    ce |=> (register_target == $past({register_select_high, st_ff.cfg.register_select_low}));
  endproperty
  a_target: assert property (p_target)
    else $error("register target does not follow selection");

endmodule : token_net_config_setup_regs

// [host_bus_model.sv]
// host model: byte writes and reads on the register strobes
// assumes the strobes are sampled on the rising edge of clk
`timescale 1ns/1ps
module host_bus_model
  import net_cfg_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [7:0]        host_rdata,
  output net_cfg_pkg::host_req_s host_req
);
  initial host_req = '0;
  // ==========================================================
  // released address and data show the inverse of the last value
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    host_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    #1;
    host_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    host_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk);
    #1;
    host_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hff};
    d = host_rdata;
  endtask : rd
endmodule : host_bus_model

// [token_net_config_setup_regs_tb.sv]
// self-checking bench of the configuration and first setup registers
// assumes host_bus_model drives the register strobes
`timescale 1ns/1ps
module token_net_config_setup_regs_tb;
  import net_cfg_pkg::*;
  localparam int unsigned RL = 40, RG = 30, IL = 50, IG = 35, IS = 25, CL = 200, CS = 100;
  logic clk = 0, sys_rst = 1, register_select_high = 0, nack_seen = 0;
  logic [1:0] reconfig_time_multiplier = 0;
  logic [7:0] ext_rdata = 0, node_id = 0, d;
  pkt_s pkt = '0;
  pulse_req_s pulse_req = '0;
  host_req_s host_req;
  reg_target_e register_target;
  timeouts_s timeouts;
  logic [7:0] host_rdata;
  logic sw, cce, bpm, p1n, p1oe, p2n, txp, acc, ack, exn, rt, at;
  int n_mismatch = 0, checked = 0;
  always #10 clk = ~clk;
  host_bus_model host_u (.clk(clk), .host_rdata(host_rdata), .host_req(host_req));
  token_net_config_setup_regs #(.RESP_LONGEST_CYC(RL), .RESP_LONG_CYC(RG),
    .IDLE_LONGEST_CYC(IL), .IDLE_LONG_CYC(IG), .IDLE_SHORT_CYC(IS),
    .RCFG_LONG_P_CYC(CL), .RCFG_SHORT_P_CYC(CS)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .ce(1'b1), .host_req(host_req), .ext_rdata(ext_rdata),
    .register_select_high(register_select_high),
    .reconfig_time_multiplier(reconfig_time_multiplier), .nack_seen(nack_seen),
    .pkt(pkt), .node_id(node_id), .pulse_req(pulse_req), .host_rdata(host_rdata),
    .software_reset(sw), .command_chain_enable(cce), .backplane_mode(bpm),
    .register_target(register_target), .timeouts(timeouts), .first_pulse_output_n(p1n),
    .first_pulse_oe(p1oe), .second_pulse_output_n(p2n), .tx_enable_pin(txp),
    .packet_accept(acc), .packet_ack(ack), .excessive_nack_flag(exn),
    .rate_tick(rt), .arb_tick(at));
  // ==========================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] s);
    checked++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask : chk
  function automatic logic [95:0] to_exp(input logic [1:0] et, input logic [1:0] m);
    case (et)
      2'h0: to_exp = {RL, IL, CL << m};
      2'h1: to_exp = {RG, IG, CL << m};
      2'h2: to_exp = {RESP2_CYC, IS, CL << m};
      default: to_exp = {RESP3_CYC, IDLE3_CYC, CS << m};
    endcase
  endfunction : to_exp
  task automatic tick_wait();
    for (int i = 0; i < 300 && rt !== 1'b1; i++) step(1);
    step(1);
  endtask : tick_wait
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  initial
  begin
    #400000;
    n_mismatch++;
    complete_run();
  end
  // ==========================================================
  // scenarios
  initial
  begin
    int n;
    void'($urandom(93));
    step(5);
    sys_rst = 0;
    chk("timeouts", to_exp(0, 0), timeouts);
    chk("txpin", 4'b0111, {txp, p1n, p2n, at});
    host_u.rd(CFG_ADDR, d);
    chk("cfg", CFG_RST_VAL, d);
    host_u.wr(CFG_ADDR, 8'hc2);
    step(1);
    chk("swrst", 3'b111, {sw, cce, register_target == SEL_SETUP1});
    host_u.wr(SUBREG_ADDR, 8'hff);
    host_u.wr(CFG_ADDR, 8'h02);
    host_u.rd(SUBREG_ADDR, d);
    chk("setup", {8'hdf, 1'b0}, {d, sw});
    for (int k = 0; k < 8; k++)
    begin
      register_select_high = k[2];
      host_u.wr(CFG_ADDR, {6'h00, k[1:0]});
      step(2);
      chk("target", k[2:0], register_target);
    end
    ext_rdata = 8'($urandom);
    host_u.rd(SUBREG_ADDR, d);
    chk("reserved", ext_rdata, d);
    register_select_high = 0;
    for (int k = 0; k < 4; k++)
    begin
      reconfig_time_multiplier = 2'($urandom);
      host_u.wr(CFG_ADDR, {3'h0, k[1:0], 3'h2});
      step(2);
      chk("timeouts", to_exp(k[1:0], reconfig_time_multiplier), timeouts);
    end
    pulse_req = '{tx_active: 1'b1, p1: 1'b1, p2: 1'b1};
    step(1);
    chk("pulse", 3'b011, {txp, p1n, p2n});
    host_u.wr(CFG_ADDR, 8'h22);
    step(1);
    chk("pulse", 4'b1000, {txp, p1n, p2n, bpm});
    host_u.wr(CFG_ADDR, 8'h26);
    step(1);
    chk("bp", 4'b1011, {bpm, p1n, p2n, p1oe});
    host_u.wr(SUBREG_ADDR, 8'h00);
    pulse_req.p1 = 0;
    step(1);
    chk("oe", 2'b10, {p1n, p1oe});
    host_u.wr(SUBREG_ADDR, 8'h80);
    step(1);
    chk("oe", 1, p1oe);
    host_u.wr(SUBREG_ADDR, 8'h40);
    for (int k = 0; k < 132; k++)
    begin
      nack_seen = 1;
      step(1);
      nack_seen = 0;
      step(1);
      chk("nack", (k == 3) || (k == 131), exn);
      if (k == 3) host_u.wr(CFG_ADDR, 8'ha2);
      if (k == 3) host_u.wr(CFG_ADDR, 8'h22);
      if (k == 3) host_u.wr(SUBREG_ADDR, 8'h00);
    end
    chk("nack128", 1, exn);
    node_id = 8'($urandom);
    host_u.wr(SUBREG_ADDR, 8'h10);
    pkt = '{valid: 1'b1, dest: node_id + 8'(1 + $urandom % 255)};
    step(1);
    pkt.valid = 0;
    chk("all", 2'b10, {acc, ack});
    pkt = '{valid: 1'b1, dest: node_id};
    step(1);
    pkt.valid = 0;
    chk("own", 2'b11, {acc, ack});
    for (int c = 0; c < 5; c++)
    begin
      host_u.wr(SUBREG_ADDR, {4'h0, c[2:0], 1'b1});
      tick_wait();
      tick_wait();
      n = 1;
      while (rt !== 1'b1 && n < 300)
      begin
        step(1);
        n++;
      end
      chk("period", 8 << c, n);
      d[0] = at;
      step(1);
      chk("arb", !d[0], at);
    end
    complete_run();
  end
endmodule : token_net_config_setup_regs_tb
